// ### rtl/pal_pkg.sv
// Package for the port latch and alternate pin select block
package pal_pkg;

  // Ports handled by the block, in slice order
  localparam int PAL_NPORT = 5;
  localparam int PAL_P2 = 0;
  localparam int PAL_P3 = 1;
  localparam int PAL_P4 = 2;
  localparam int PAL_P6 = 3;
  localparam int PAL_P12 = 4;

  // Register indexes; the byte address is four times the index
  localparam logic [15:0] PAL_IDX_LATCH = 16'hff00;
  localparam logic [15:0] PAL_IDX_RMW = 16'hff10;
  localparam logic [15:0] PAL_IDX_DIR = 16'hff20;
  localparam logic [15:0] PAL_IDX_ADPC = 16'hff2e;
  localparam logic [15:0] PAL_IDX_ALT_S = 16'hff39;
  localparam logic [15:0] PAL_IDX_ALT_L = 16'hff3f;
  localparam logic [15:0] PAL_IDX_RSTMSK = 16'hff40;
  localparam logic [15:0] PAL_IDX_OSC = 16'hff41;

  // Values after reset
  localparam logic [7:0] PAL_LATCH_RST = 8'h00;
  localparam logic [7:0] PAL_DIR_RST = 8'hff;
  localparam logic [7:0] PAL_ADPC_RST = 8'h00;
  localparam logic [7:0] PAL_ALT_RST = 8'h00;
  localparam logic [7:0] PAL_RSTMSK_RST = 8'h00;
  localparam logic [7:0] PAL_OSC_RST = 8'h00;

  // Field positions and writable masks
  localparam int PAL_IRQ0_LSB = 6;
  localparam int PAL_CAP_LSB = 4;
  localparam int PAL_TH1_BIT = 0;
  localparam int PAL_CSI_BIT = 2;
  localparam int PAL_RESET_MASK_BIT_BIT = 5;
  localparam int PAL_OSC_LSB = 6;
  localparam logic [7:0] PAL_ALT_S_MASK = 8'hf1;
  localparam logic [7:0] PAL_ALT_L_MASK = 8'h04;

  // Pin positions of the alternate functions
  localparam int PAL_TH1_PIN = 4;
  localparam int PAL_P12_B0 = 0;
  localparam int PAL_P12_B1 = 1;
  localparam int PAL_P12_B2 = 2;
  localparam int PAL_P12_B5 = 5;

  typedef enum logic [1:0] {
    PAL_RT_NONE = 2'b00,
    PAL_RT_B1 = 2'b01,
    PAL_RT_B5 = 2'b10,
    PAL_RT_BAD = 2'b11
  } pal_route_t;

  typedef enum logic [1:0] {
    PAL_OSC_PORT = 2'b00,
    PAL_OSC_XTAL = 2'b01,
    PAL_OSC_EXTCLK = 2'b10,
    PAL_OSC_RSVD = 2'b11
  } pal_osc_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } pal_apb_t;

  typedef struct packed {
    logic clk_out;
    logic clk_drive;
    logic data_out;
  } pal_csi_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] sync1;
    logic [7:0] sync2;
  } pal_port_t;

  typedef struct packed {
    logic [7:0] adpc;
    logic [7:0] osc;
    logic [7:0] rstmsk;
    logic [7:0] alt_s;
    logic [7:0] alt_l;
    logic [31:0] prdata;
    logic slverr;
  } pal_regs_t;

endpackage

// ### rtl/pal_port.sv
// One 8-bit port: output latch, direction, pin synchroniser
`timescale 1ns/10ps
module pal_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register side
  input wire logic wr_latch,
  input wire logic wr_dir,
  input wire logic wr_rmw,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rmw_mask,
  // Pin side
  input wire logic [7:0] pin_i,
  output logic [7:0] latch,
  output logic [7:0] dir,
  output logic [7:0] pin_lvl,
  output logic [7:0] rd_val
);
  import pal_pkg::*;

  pal_port_t s_q;
  pal_port_t s_d;
  logic [7:0] operand;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = pin_i;
    s_d.sync2 = s_q.sync1;
    // operand per bit: pin in input mode, latch otherwise
    operand = (s_q.dir & s_q.sync2) | (~s_q.dir & s_q.latch);
    if (wr_latch) begin
      s_d.latch = wdata;
    end else if (wr_rmw) begin
      s_d.latch = (operand & ~rmw_mask) | (wdata & rmw_mask);
    end
    if (wr_dir) begin
      s_d.dir = wdata;
    end
  end

  // latch held until written, cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{latch: PAL_LATCH_RST, dir: PAL_DIR_RST,
               sync1: 8'h00, sync2: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign latch = s_q.latch;
  assign dir = s_q.dir;
  assign pin_lvl = s_q.sync2;
  // read latch in output mode, pin in input
  assign rd_val = (s_q.dir & s_q.sync2) | (~s_q.dir & s_q.latch);

endmodule

// ### rtl/pal_top.sv
// Port latches, alternate pin routing and APB register file
//
// Behaviour
// - Small register bits 7:6 route irq0 input
// - Small register bits 5:4 route capture input
// - Small register bit 0 drives timer out
// - Large register: only bit 2, resets zero
// - Serial select moves serial pins between ports
// - Output mode write loads latch, drives pin
// - Latch holds value until next write
// - Reset clears every output latch
// - Input mode write loads latch, pin undriven
// - Output mode read returns latch
// - Input mode read returns pin level
// - Output mode modify uses latch operand
// - Input mode modify uses pin operand
// - Oscillator register resets zero, pins stay ports
// - Select bit zero analog, one digital
// - Assignment register byte or bit written, reset zero
`timescale 1ns/10ps
module pal_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire pal_pkg::pal_apb_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins
  input wire logic [pal_pkg::PAL_NPORT-1:0][7:0] pin_i,
  output logic [pal_pkg::PAL_NPORT-1:0][7:0] pin_o,
  output logic [pal_pkg::PAL_NPORT-1:0][7:0] pin_oe_n,
  // Peripheral side
  input wire logic timer_h1_output,
  input wire pal_pkg::pal_csi_t csi,
  output logic ext_irq0_input,
  output logic timer16_capture_input,
  output logic serial_chan_clock,
  output logic serial_chan_in,
  output logic ext_reset_req,
  output logic [7:0] analog_en,
  output logic [1:0] osc_mode
);
  import pal_pkg::*;

  pal_regs_t r_q;
  pal_regs_t r_d;

  logic [PAL_NPORT-1:0][7:0] latch;
  logic [PAL_NPORT-1:0][7:0] dir;
  logic [PAL_NPORT-1:0][7:0] pin_lvl;
  logic [PAL_NPORT-1:0][7:0] rd_val;
  logic [PAL_NPORT-1:0] wr_latch;
  logic [PAL_NPORT-1:0] wr_dir;
  logic [PAL_NPORT-1:0] wr_rmw;

  logic [15:0] idx;
  logic setup;
  logic wr_acc;
  logic hit;
  logic [7:0] rdat;
  logic [7:0] wbyte;
  logic [7:0] wmask;
  logic [7:0] alt_s_new;
  logic [7:0] alt_s_merge;
  logic [7:0] alt_l_merge;
  logic [7:0] osc_claim;
  logic csi_sel;
  logic th1_on;

  // Keep a field when software writes the forbidden code
  function automatic logic [1:0] pal_route_keep(input logic [1:0] nv,
                                                input logic [1:0] ov);
    pal_route_keep = (nv == PAL_RT_BAD) ? ov : nv;
  endfunction

  // Pick one pin of port 12 by route code
  function automatic logic pal_route_pick(input logic [1:0] rt,
                                          input logic [7:0] lvl);
    logic v;
    v = 1'b0;
    unique case (rt)
      PAL_RT_NONE: v = 1'b0;
      PAL_RT_B1: v = lvl[PAL_P12_B1];
      PAL_RT_B5: v = lvl[PAL_P12_B5];
      PAL_RT_BAD: v = 1'b0;
    endcase
    pal_route_pick = v;
  endfunction

  // Whole byte when the mask is zero, else only the masked bits
  function automatic logic [7:0] pal_bit_merge(input logic [7:0] ov,
                                               input logic [7:0] nv,
                                               input logic [7:0] m);
    logic [7:0] v;
    v = nv;
    if (m != 8'h00) begin
      v = (ov & ~m) | (nv & m);
    end
    pal_bit_merge = v;
  endfunction

  // Bus decode
  assign idx = apb.paddr[17:2];
  assign setup = apb.psel && !apb.penable;
  assign wr_acc = apb.psel && apb.penable && apb.pwrite;
  assign wbyte = apb.pwdata[7:0];
  assign wmask = apb.pwdata[15:8];

  // Port slices
  for (genvar k = 0; k < PAL_NPORT; k++) begin : g_port
    assign wr_latch[k] = wr_acc && (idx == PAL_IDX_LATCH + 16'(k));
    assign wr_dir[k] = wr_acc && (idx == PAL_IDX_DIR + 16'(k));
    assign wr_rmw[k] = wr_acc && (idx == PAL_IDX_RMW + 16'(k));
    pal_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .wr_latch(wr_latch[k]),
      .wr_dir(wr_dir[k]),
      .wr_rmw(wr_rmw[k]),
      .wdata(wbyte),
      .rmw_mask(wmask),
      .pin_i(pin_i[k]),
      .latch(latch[k]),
      .dir(dir[k]),
      .pin_lvl(pin_lvl[k]),
      .rd_val(rd_val[k])
    );
  end

  // Oscillator pins taken from port 12
  always_comb begin
    osc_claim = 8'h00;
    unique case (pal_osc_t'(r_q.osc[PAL_OSC_LSB +: 2]))
      PAL_OSC_PORT: osc_claim = 8'h00;
      PAL_OSC_XTAL: begin
        osc_claim[PAL_P12_B1] = 1'b1;
        osc_claim[PAL_P12_B2] = 1'b1;
      end
      PAL_OSC_EXTCLK: osc_claim[PAL_P12_B2] = 1'b1;
      PAL_OSC_RSVD: osc_claim = 8'h00;
    endcase
  end

  // Read mux
  always_comb begin
    rdat = 8'h00;
    hit = 1'b1;
    if (idx >= PAL_IDX_LATCH && idx < PAL_IDX_LATCH + 16'(PAL_NPORT)) begin
      rdat = rd_val[3'(idx - PAL_IDX_LATCH)];
      if (idx == PAL_IDX_LATCH + 16'(PAL_P2)) begin
        rdat = rdat & r_q.adpc;
      end
      if (idx == PAL_IDX_LATCH + 16'(PAL_P12)) begin
        rdat = rdat & ~osc_claim;
      end
    end else if (idx >= PAL_IDX_RMW &&
                 idx < PAL_IDX_RMW + 16'(PAL_NPORT)) begin
      rdat = latch[3'(idx - PAL_IDX_RMW)];
    end else if (idx >= PAL_IDX_DIR &&
                 idx < PAL_IDX_DIR + 16'(PAL_NPORT)) begin
      rdat = dir[3'(idx - PAL_IDX_DIR)];
    end else if (idx == PAL_IDX_ADPC) begin
      rdat = r_q.adpc;
    end else if (idx == PAL_IDX_ALT_S) begin
      rdat = r_q.alt_s;
    end else if (idx == PAL_IDX_ALT_L) begin
      rdat = r_q.alt_l;
    end else if (idx == PAL_IDX_RSTMSK) begin
      rdat = r_q.rstmsk;
    end else if (idx == PAL_IDX_OSC) begin
      rdat = r_q.osc;
    end else begin
      hit = 1'b0;
    end
  end

  // a nonzero mask byte writes single bits
  assign alt_s_merge = pal_bit_merge(r_q.alt_s, wbyte, wmask);
  // serial select bit writable alone as well
  assign alt_l_merge = pal_bit_merge(r_q.alt_l, wbyte, wmask);

  // Small assignment register with forbidden codes refused
  always_comb begin
    alt_s_new = alt_s_merge & PAL_ALT_S_MASK;
    // forbidden irq0 code keeps old route
    alt_s_new[PAL_IRQ0_LSB +: 2] =
      pal_route_keep(alt_s_merge[PAL_IRQ0_LSB +: 2],
                     r_q.alt_s[PAL_IRQ0_LSB +: 2]);
    // forbidden capture code keeps old route
    alt_s_new[PAL_CAP_LSB +: 2] =
      pal_route_keep(alt_s_merge[PAL_CAP_LSB +: 2],
                     r_q.alt_s[PAL_CAP_LSB +: 2]);
  end

  // Register file next state
  always_comb begin
    r_d = r_q;
    // Read data is captured in the setup cycle
    if (setup) begin
      r_d.prdata = {24'h000000, rdat};
      r_d.slverr = !hit;
    end
    if (wr_acc) begin
      if (idx == PAL_IDX_ADPC) begin
        r_d.adpc = wbyte;
      end
      // whole byte or masked bits written, fixed bits dropped
      if (idx == PAL_IDX_ALT_S) begin
        r_d.alt_s = alt_s_new;
      end
      // only the serial select bit stores
      if (idx == PAL_IDX_ALT_L) begin
        r_d.alt_l = alt_l_merge & PAL_ALT_L_MASK;
      end
      if (idx == PAL_IDX_RSTMSK) begin
        r_d.rstmsk = wbyte;
      end
      if (idx == PAL_IDX_OSC) begin
        r_d.osc = wbyte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '{adpc: PAL_ADPC_RST, osc: PAL_OSC_RST,
               rstmsk: PAL_RSTMSK_RST, alt_s: PAL_ALT_RST,
               alt_l: PAL_ALT_RST, prdata: 32'h00000000,
               slverr: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // Zero wait answer in the access cycle
  assign pready = apb.psel && apb.penable;
  assign prdata = r_q.prdata;
  assign pslverr = pready && r_q.slverr;

  assign csi_sel = r_q.alt_l[PAL_CSI_BIT];
  assign th1_on = r_q.alt_s[PAL_TH1_BIT];

  // Pin drive with alternate overrides
  always_comb begin
    for (int k = 0; k < PAL_NPORT; k++) begin
      // buffer on only in output mode
      pin_o[k] = latch[k];
      pin_oe_n[k] = dir[k];
    end
    // timer output onto port 3 bit 4
    if (th1_on) begin
      pin_o[PAL_P3][PAL_TH1_PIN] = timer_h1_output;
    end
    // serial clock and data out pins
    if (csi_sel) begin
      if (csi.clk_drive) begin
        pin_o[PAL_P4][0] = csi.clk_out;
      end
      pin_o[PAL_P12][PAL_P12_B0] = csi.data_out;
    end else begin
      if (csi.clk_drive) begin
        pin_o[PAL_P6][0] = csi.clk_out;
      end
      pin_o[PAL_P6][2] = csi.data_out;
    end
    pin_oe_n[PAL_P2] = dir[PAL_P2] | ~r_q.adpc;
    // oscillator pins released from the port
    pin_oe_n[PAL_P12] = dir[PAL_P12] | osc_claim;
  end

  assign ext_irq0_input =
    pal_route_pick(r_q.alt_s[PAL_IRQ0_LSB +: 2], pin_lvl[PAL_P12]);
  assign timer16_capture_input =
    pal_route_pick(r_q.alt_s[PAL_CAP_LSB +: 2], pin_lvl[PAL_P12]);

  // serial inputs from the selected pins
  assign serial_chan_clock = csi_sel ? pin_lvl[PAL_P4][0] :
                             pin_lvl[PAL_P6][0];
  assign serial_chan_in = csi_sel ? pin_lvl[PAL_P4][1] :
                          pin_lvl[PAL_P6][1];

  // reset pin acts only when unmasked
  assign ext_reset_req = !r_q.rstmsk[PAL_RESET_MASK_BIT_BIT] &&
                         !pin_lvl[PAL_P12][PAL_P12_B5];

  assign analog_en = ~r_q.adpc;
  assign osc_mode = r_q.osc[PAL_OSC_LSB +: 2];

endmodule

// ### tb/pal_ext_pins.sv
// Model of the circuitry attached to the port pins
`timescale 1ns/10ps
module pal_ext_pins (
  // Block side
  input wire logic [pal_pkg::PAL_NPORT-1:0][7:0] pin_o,
  input wire logic [pal_pkg::PAL_NPORT-1:0][7:0] pin_oe_n,
  // Bench control
  input wire logic [pal_pkg::PAL_NPORT-1:0][7:0] ext,
  input wire logic fight,
  // Pin levels
  output logic [pal_pkg::PAL_NPORT-1:0][7:0] pin_i
);
  import pal_pkg::*;
  // outside level on released pins, on every pin while fight is set
  assign pin_i = fight ? ext : (pin_o & ~pin_oe_n) | (ext & pin_oe_n);
endmodule

// ### tb/pal_props.sv
// Assertion checker for the port latch and pin select block
`timescale 1ns/10ps
module pal_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire pal_pkg::pal_apb_t apb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic [pal_pkg::PAL_NPORT-1:0][7:0] pin_i,
  input wire logic [pal_pkg::PAL_NPORT-1:0][7:0] pin_o,
  input wire logic [pal_pkg::PAL_NPORT-1:0][7:0] pin_oe_n,
  // Peripheral side
  input wire logic timer_h1_output,
  input wire pal_pkg::pal_csi_t csi,
  input wire logic ext_irq0_input,
  input wire logic timer16_capture_input,
  input wire logic serial_chan_clock,
  input wire logic serial_chan_in,
  input wire logic ext_reset_req,
  input wire logic [7:0] analog_en,
  input wire logic [1:0] osc_mode
);
  import pal_pkg::*;
  typedef struct packed {
    logic [1:0] irq;
    logic [1:0] cap;
    logic th1;
    logic csi;
    logic [1:0] age;
  } pal_shadow_t;
  pal_shadow_t s_q, s_d;
  logic wr;
  logic [15:0] idx;
  logic [7:0] bm;
  logic [7:0] nv;
  assign wr = apb.psel & apb.penable & apb.pwrite;
  assign idx = apb.paddr[17:2];
  // Nonzero mask byte writes only the masked bits
  assign bm = (apb.pwdata[15:8] == 8'h00) ? 8'hff : apb.pwdata[15:8];
  assign nv = (apb.pwdata[7:0] & bm) |
              ({s_q.irq, s_q.cap, 3'b000, s_q.th1} & ~bm);
  // Shadow of the routing fields, age gates synchroniser history
  always_comb begin
    s_d = s_q;
    if (s_q.age != 2'd3) s_d.age = s_q.age + 2'd1;
    if (wr && idx == PAL_IDX_ALT_S) begin
      if (nv[7:6] != 2'b11) s_d.irq = nv[7:6];
      if (nv[5:4] != 2'b11) s_d.cap = nv[5:4];
      s_d.th1 = nv[0];
    end
    if (wr && idx == PAL_IDX_ALT_L) begin
      s_d.csi = (apb.pwdata[2] & bm[2]) | (s_q.csi & ~bm[2]);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= '0;
    else s_q <= s_d;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_access_a: assert property (
    pready == (apb.psel && apb.penable)) else $error("pready wrong");
  reset_release_a: assert property (
    $rose(presetn) |-> pin_oe_n == '1 && pin_o[1][3:0] == 4'h0)
    else $error("pins not cleared by reset");
  latch_hold_a: assert property (
    !(wr && (idx == PAL_IDX_LATCH + 16'd1 || idx == PAL_IDX_RMW + 16'd1))
    |=> $stable(pin_o[1][3:0])) else $error("latch moved without write");
  latch_drive_a: assert property (
    wr && idx == PAL_IDX_LATCH + 16'd1
    |=> pin_o[1][3:0] == $past(apb.pwdata[3:0])) else $error("latch drive");
  dir_enable_a: assert property (
    wr && idx == PAL_IDX_DIR + 16'd1
    |=> pin_oe_n[1] == $past(apb.pwdata[7:0])) else $error("enable wrong");
  irq_route_a: assert property (
    s_q.age == 2'd3 |-> ext_irq0_input == (s_q.irq == 2'b01 ?
    $past(pin_i[4][1], 2) : s_q.irq == 2'b10 ? $past(pin_i[4][5], 2) : 1'b0))
    else $error("irq0 route wrong");
  cap_route_a: assert property (
    s_q.age == 2'd3 |-> timer16_capture_input == (s_q.cap == 2'b01 ?
    $past(pin_i[4][1], 2) : s_q.cap == 2'b10 ? $past(pin_i[4][5], 2) : 1'b0))
    else $error("capture route wrong");
  timer_route_a: assert property (
    s_q.th1 |-> pin_o[1][4] == timer_h1_output) else $error("timer route");
  serial_pins_a: assert property (
    s_q.age == 2'd3 |-> {serial_chan_in, serial_chan_clock} == (s_q.csi ?
    $past(pin_i[2][1:0], 2) : $past(pin_i[3][1:0], 2)))
    else $error("serial pins wrong");
  read_zero_a: assert property (
    pready |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
    else $error("read data upper bits set");
  cover property (wr && idx == PAL_IDX_ALT_S);
  cover property (pslverr);
  cover property (s_q.csi && serial_chan_clock);
endmodule

bind pal_top pal_props u_props (.pclk(pclk), .presetn(presetn), .apb(apb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_n(pin_oe_n), .timer_h1_output(timer_h1_output),
  .csi(csi), .ext_irq0_input(ext_irq0_input),
  .timer16_capture_input(timer16_capture_input),
  .serial_chan_clock(serial_chan_clock), .serial_chan_in(serial_chan_in),
  .ext_reset_req(ext_reset_req), .analog_en(analog_en), .osc_mode(osc_mode));

// ### tb/testbench.sv
// Self-checking bench for the port latch and pin select block
`timescale 1ns/10ps
module testbench;
  import pal_pkg::*;
  logic pclk, presetn, th1, fight, pready, pslverr, err;
  logic irq, cap, sclk, sin, rreq;
  logic [31:0] prdata, rd;
  logic [7:0] aen;
  logic [1:0] osc;
  logic [PAL_NPORT-1:0][7:0] pin_i, pin_o, pin_oe_n, ext;
  pal_apb_t apb;
  pal_csi_t csi;
  int errors, checks;
  pal_top dut (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .timer_h1_output(th1), .csi(csi),
    .ext_irq0_input(irq), .timer16_capture_input(cap),
    .serial_chan_clock(sclk), .serial_chan_in(sin), .ext_reset_req(rreq),
    .analog_en(aen), .osc_mode(osc));
  pal_ext_pins ext_pins (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext(ext),
    .fight(fight), .pin_i(pin_i));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] ix,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= w;
    apb.paddr <= {ix, 2'b00};
    apb.pwdata <= d;
    @(posedge pclk);
    apb.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  task automatic wreg(input logic [15:0] ix, input logic [31:0] d);
    xfer(1'b1, ix, d);
  endtask
  task automatic rchk(input logic [15:0] ix, input logic [31:0] e);
    xfer(1'b0, ix, 32'h0);
    check(rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    presetn = 1'b0;
    apb = '0;
    csi = '0;
    ext = '0;
    th1 = 1'b0;
    fight = 1'b0;
    errors = 0;
    checks = 0;
    cyc(2);
    presetn <= 1'b1;
    rchk(PAL_IDX_ALT_S, 32'h0);
    rchk(PAL_IDX_ALT_L, 32'h0);
    rchk(PAL_IDX_OSC, 32'h0);
    check(osc, 32'h0);
    check(aen, 32'hff);
    ext[1] <= 8'ha5;
    cyc(3);
    rchk(PAL_IDX_LATCH + 16'h1, 32'ha5);
    wreg(PAL_IDX_LATCH + 16'h1, 32'h3c);
    cyc(1);
    check(pin_oe_n[1], 32'hff);
    rchk(PAL_IDX_LATCH + 16'h1, 32'ha5);
    wreg(PAL_IDX_DIR + 16'h1, 32'h0);
    cyc(1);
    check(pin_o[1], 32'h3c);
    fight <= 1'b1;
    cyc(3);
    rchk(PAL_IDX_LATCH + 16'h1, 32'h3c);
    wreg(PAL_IDX_RMW + 16'h1, 32'h0f0f);
    cyc(1);
    check(pin_o[1], 32'h3f);
    fight <= 1'b0;
    wreg(PAL_IDX_DIR + 16'h1, 32'hff);
    cyc(3);
    wreg(PAL_IDX_RMW + 16'h1, 32'h0f00);
    cyc(1);
    check(pin_oe_n[1], 32'hff);
    wreg(PAL_IDX_DIR + 16'h1, 32'h0);
    cyc(1);
    check(pin_o[1], 32'ha0);
    wreg(PAL_IDX_ALT_S, 32'h91);
    rchk(PAL_IDX_ALT_S, 32'h91);
    wreg(PAL_IDX_ALT_S, 32'hff);
    rchk(PAL_IDX_ALT_S, 32'h91);
    wreg(PAL_IDX_ALT_S, 32'h9f);
    rchk(PAL_IDX_ALT_S, 32'h91);
    th1 <= 1'b1;
    cyc(1);
    check(pin_o[1][4], 32'h1);
    for (int c = 0; c < 3; c++) begin
      wreg(PAL_IDX_ALT_S, {24'h0, c[1:0], c[1:0], 4'h0});
      cyc(1);
      check(pin_o[1][4], 32'h0);
      for (int p = 0; p < 2; p++) begin
        ext[4] <= p ? 8'h20 : 8'h02;
        cyc(3);
        check({irq, cap}, {2{c == p + 1}});
      end
    end
    wreg(PAL_IDX_ALT_S, 32'h0101);
    rchk(PAL_IDX_ALT_S, 32'ha1);
    check(pin_o[1][4], 32'h1);
    wreg(PAL_IDX_ALT_L, 32'hff);
    rchk(PAL_IDX_ALT_L, 32'h04);
    ext[2] <= 8'h01;
    ext[3] <= 8'h02;
    csi <= '1;
    for (int s = 1; s >= 0; s--) begin
      wreg(PAL_IDX_ALT_L, s ? 32'h04 : 32'h0);
      cyc(3);
      check({sclk, sin}, s ? 32'h2 : 32'h1);
      check({pin_o[2][0], pin_o[4][0], pin_o[3][2], pin_o[3][0]},
            s ? 32'hc : 32'h3);
    end
    csi <= '0;
    wreg(PAL_IDX_LATCH + 16'h3, 32'h03);
    wreg(PAL_IDX_DIR + 16'h3, 32'hfc);
    cyc(1);
    check({pin_o[3][1:0], pin_oe_n[3][1:0]}, 32'hc);
    wreg(PAL_IDX_DIR + 16'h3, 32'hfe);
    cyc(1);
    check({pin_o[3][0], pin_oe_n[3][1:0]}, 32'h6);
    wreg(PAL_IDX_ADPC, 32'hff);
    cyc(1);
    check(aen, 32'h0);
    wreg(PAL_IDX_ADPC, 32'h0f);
    ext[0] <= 8'hff;
    cyc(3);
    rchk(PAL_IDX_LATCH, 32'h0f);
    ext[4] <= 8'h06;
    cyc(3);
    check(rreq, 32'h1);
    rchk(PAL_IDX_LATCH + 16'h4, 32'h06);
    wreg(PAL_IDX_RSTMSK, 32'h20);
    wreg(PAL_IDX_OSC, 32'h40);
    wreg(PAL_IDX_DIR + 16'h4, 32'h0);
    cyc(1);
    check({rreq, osc, pin_oe_n[4]}, 32'h106);
    rchk(PAL_IDX_LATCH + 16'h4, 32'h0);
    xfer(1'b0, 16'hff30, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    presetn <= 1'b0;
    cyc(2);
    check(pin_o[1], 32'h0);
    presetn <= 1'b1;
    rchk(PAL_IDX_ALT_S, 32'h0);
    final_report();
  end
endmodule
